// [inc/pph_pkg.sv]
// Constants shared by the parallel port handshake block.
`default_nettype none
package pph_pkg;

	// ------------------------------------------------------------
	// Widths and counts
	// ------------------------------------------------------------
	localparam int unsigned PORT_W  = 8;
	localparam int unsigned ADDR_W  = 4;
	localparam int unsigned NPORT   = 2;
	localparam int unsigned SYNC_N  = 3;

	// ------------------------------------------------------------
	// Register indices
	// ------------------------------------------------------------
	localparam logic [3:0] REG_PORTB_DATA = 4'h0;
	localparam logic [3:0] REG_PORTA_DATA = 4'h1;
	localparam logic [3:0] REG_PORTB_DIR  = 4'h2;
	localparam logic [3:0] REG_PORTA_DIR  = 4'h3;
	localparam logic [3:0] REG_AUX_CTRL   = 4'hB;
	localparam logic [3:0] REG_LINE_CTRL  = 4'hC;
	localparam logic [3:0] REG_EVT_FLAGS  = 4'hD;

	// ------------------------------------------------------------
	// Field positions (port A then port B)
	// ------------------------------------------------------------
	localparam int unsigned LC_EDGE_A  = 0;
	localparam int unsigned LC_MODE_A  = 1;
	localparam int unsigned LC_LEVEL_A = 2;
	localparam int unsigned LC_OUT_A   = 3;
	localparam int unsigned LC_EDGE_B  = 4;
	localparam int unsigned LC_MODE_B  = 5;
	localparam int unsigned LC_LEVEL_B = 6;
	localparam int unsigned LC_OUT_B   = 7;
	localparam int unsigned AUX_LATCH_A = 0;
	localparam int unsigned AUX_LATCH_B = 1;
	localparam int unsigned FLAG_A      = 1;
	localparam int unsigned FLAG_B      = 4;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic       RST_LINE = 1'b1;

endpackage : pph_pkg

`default_nettype wire

// [logic/pph_top.sv]
// Two 8-bit parallel ports with status-input events and control-line handshakes.
//
// Contract
// (R1) A direction bit of one drives its pin; zero leaves it an input.
// (R2) Port reads return pins; port B returns driven value for output bits.
// (R3) Line control bit 0 (A) and 4 (B) choose rising edges when set.
// (R4) An active status edge sets event flag bit 1 (A) or 4 (B).
// (R5) Reading or writing a port data register clears its event flag.
// (R6) Every processor store to a port data register latches output data.
// (R7) Auxiliary bit 0 (A) or 1 (B) latches input data on active edges.
// (R8) Line control bit 3 (A) or 7 (B) makes the control line an output.
// (R9) Line control bit 2 (A) or 6 (B): clear pulse, set static level.
// (R10) In pulse mode, bit 1 (A) or 5 (B): clear handshake, set strobe.
// (R11) In level mode the line drives line control bit 1 (A) or 5 (B).
// (R12) Handshake: line low on data access, high on next active status edge.
// (R13) Strobe: line low on data access, high again after one cycle.
// (R14) The peripheral gives one transition of chosen polarity per event.
// (R15) The line control register resets to zero.
// (R16) Port B control line behaves as port A with its own resources.
// (R17) Edges are sampled on the clock; a set beats a same-cycle clear.
`timescale 1ns/1ps
`default_nettype none

module pph_top
	import pph_pkg::*;
(
	input  wire logic              sys_clk,
	input  wire logic              nrst,
	input  wire logic              clk_en,
	input  wire logic [ADDR_W-1:0] bus_addr,
	input  wire logic              bus_rd,
	input  wire logic              bus_wr,
	input  wire logic [PORT_W-1:0] bus_wdata,
	output var  logic [PORT_W-1:0] bus_rdata,
	input  wire logic [PORT_W-1:0] porta_pins_i,
	output var  logic [PORT_W-1:0] porta_pins_o,
	output var  logic [PORT_W-1:0] porta_pins_oe,
	input  wire logic [PORT_W-1:0] portb_pins_i,
	output var  logic [PORT_W-1:0] portb_pins_o,
	output var  logic [PORT_W-1:0] portb_pins_oe,
	input  wire logic              porta_status_input,
	input  wire logic              portb_status_input,
	output var  logic              porta_control_line_o,
	output var  logic              porta_control_line_oe,
	output var  logic              portb_control_line_o,
	output var  logic              portb_control_line_oe
);

	// ------------------------------------------------------------
	// Decoding and settling helpers
	// ------------------------------------------------------------
	function automatic logic [3:0] data_reg(input int unsigned p);
		return (p == 0) ? REG_PORTA_DATA : REG_PORTB_DATA;
	endfunction : data_reg

	function automatic logic [3:0] dir_reg(input int unsigned p);
		return (p == 0) ? REG_PORTA_DIR : REG_PORTB_DIR;
	endfunction : dir_reg

	// A synchronised bit is taken only once its second and third stages agree,
	// so a pin caught mid-change never reaches the read path half-settled.
	function automatic logic [PORT_W-1:0] settle(
		input logic [PORT_W-1:0] s2,
		input logic [PORT_W-1:0] s3,
		input logic [PORT_W-1:0] held
	);
		return (s3 & ~(s2 ^ s3)) | (held & (s2 ^ s3));
	endfunction : settle

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	// Everything below is frozen while the clock enable is low.
	logic [PORT_W-1:0] line_ctrl_q;
	logic [PORT_W-1:0] aux_ctrl_q;
	logic [PORT_W-1:0] out_q   [NPORT];
	logic [PORT_W-1:0] dir_q   [NPORT];
	logic [PORT_W-1:0] latch_q [NPORT];
	logic [NPORT-1:0]  flag_q;
	logic [NPORT-1:0]  line_q;
	logic [NPORT-1:0]  line_oe_q;

	logic [PORT_W-1:0] pin_in  [NPORT];
	logic [PORT_W-1:0] pin_s1_q [NPORT];
	logic [PORT_W-1:0] pin_s2_q [NPORT];
	logic [PORT_W-1:0] pin_s3_q [NPORT];
	logic [PORT_W-1:0] pin_lvl_q [NPORT];
	logic [NPORT-1:0]  st_in;
	logic [NPORT-1:0]  st_s1_q;
	logic [NPORT-1:0]  st_s2_q;
	logic [NPORT-1:0]  st_s3_q;
	logic [NPORT-1:0]  st_lvl_q;
	logic [NPORT-1:0]  st_edge;
	logic [NPORT-1:0]  data_acc;
	logic [PORT_W-1:0] port_rd [NPORT];

	assign pin_in[0] = porta_pins_i;
	assign pin_in[1] = portb_pins_i;
	assign st_in     = {portb_status_input, porta_status_input};

	// ------------------------------------------------------------
	// Shared control registers
	// ------------------------------------------------------------
	// The flags register has no write path: flags clear only through port
	// data accesses, so a stray store cannot lose a pending event.
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			line_ctrl_q <= RST_BYTE; // R15
		end else if (clk_en && bus_wr && bus_addr == REG_LINE_CTRL) begin
			line_ctrl_q <= bus_wdata;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			aux_ctrl_q <= RST_BYTE;
		end else if (clk_en && bus_wr && bus_addr == REG_AUX_CTRL) begin
			aux_ctrl_q <= bus_wdata;
		end
	end

	// ------------------------------------------------------------
	// Per-port logic
	// ------------------------------------------------------------
	for (genvar p = 0; p < NPORT; p++) begin : g_port
		// Port A takes the low nibble of the line control register, port B the
		// high one; the same code serves both so their behaviour cannot drift.
		localparam int unsigned EDGE_B  = (p == 0) ? LC_EDGE_A : LC_EDGE_B;
		localparam int unsigned MODE_B  = (p == 0) ? LC_MODE_A : LC_MODE_B;
		localparam int unsigned LEVEL_B = (p == 0) ? LC_LEVEL_A : LC_LEVEL_B;
		localparam int unsigned OUT_B   = (p == 0) ? LC_OUT_A : LC_OUT_B;
		localparam int unsigned LATCH_B = (p == 0) ? AUX_LATCH_A : AUX_LATCH_B;

		// Reads and writes count alike; the clock enable is applied where it is used.
		assign data_acc[p] = (bus_rd || bus_wr) && bus_addr == data_reg(p);

		// Pins and status lines come from outside, so they pass three stages.
		always_ff @(posedge sys_clk or negedge nrst) begin
			if (!nrst) begin
				pin_s1_q[p] <= RST_BYTE;
				pin_s2_q[p] <= RST_BYTE;
				pin_s3_q[p] <= RST_BYTE;
				pin_lvl_q[p] <= RST_BYTE;
				st_s1_q[p]  <= 1'b0;
				st_s2_q[p]  <= 1'b0;
				st_s3_q[p]  <= 1'b0;
				st_lvl_q[p] <= 1'b0;
			end else if (clk_en) begin
				pin_s1_q[p] <= pin_in[p];
				pin_s2_q[p] <= pin_s1_q[p];
				pin_s3_q[p] <= pin_s2_q[p];
				pin_lvl_q[p] <= settle(pin_s2_q[p], pin_s3_q[p], pin_lvl_q[p]);
				st_s1_q[p]  <= st_in[p];
				st_s2_q[p]  <= st_s1_q[p];
				st_s3_q[p]  <= st_s2_q[p];
				if (st_s2_q[p] == st_s3_q[p]) begin
					st_lvl_q[p] <= st_s3_q[p];
				end
			end
		end

		// A level change counts only once the second and third stages agree.
		// Only the selected direction counts; the return to idle is ignored.
		assign st_edge[p] = (st_s2_q[p] == st_s3_q[p]) && (st_s3_q[p] != st_lvl_q[p])
			&& (st_s3_q[p] == line_ctrl_q[EDGE_B]); // R3 R14 R17

		always_ff @(posedge sys_clk or negedge nrst) begin
			if (!nrst) begin
				out_q[p] <= RST_BYTE;
			end else if (clk_en && bus_wr && bus_addr == data_reg(p)) begin
				out_q[p] <= bus_wdata; // R6
			end
		end

		always_ff @(posedge sys_clk or negedge nrst) begin
			if (!nrst) begin
				dir_q[p] <= RST_BYTE;
			end else if (clk_en && bus_wr && bus_addr == dir_reg(p)) begin
				dir_q[p] <= bus_wdata;
			end
		end

		always_ff @(posedge sys_clk or negedge nrst) begin
			if (!nrst) begin
				latch_q[p] <= RST_BYTE;
			end else if (clk_en && st_edge[p]) begin
				latch_q[p] <= pin_lvl_q[p]; // R7
			end
		end

		// Setting wins over the clearing access so no event is lost; the access
		// that races an edge leaves the flag up for the next poll to see.
		always_ff @(posedge sys_clk or negedge nrst) begin
			if (!nrst) begin
				flag_q[p] <= 1'b0;
			end else if (clk_en) begin
				if (st_edge[p]) begin
					flag_q[p] <= 1'b1; // R4 R17
				end else if (data_acc[p]) begin
					flag_q[p] <= 1'b0; // R5
				end
			end
		end

		// Port B bits driven as outputs read back the driven value. Port A reads the pin,
		// or its latch when latching is on, for every bit, so a heavily loaded output bit
		// on A may read back wrong; that is the pin's truth, not a fault of this logic.
		assign port_rd[p] = (aux_ctrl_q[LATCH_B] ? latch_q[p] : pin_lvl_q[p]) // R7
			& ~((p == 1) ? dir_q[p] : RST_BYTE)
			| (((p == 1) ? dir_q[p] : RST_BYTE) & out_q[p]); // R2

		always_ff @(posedge sys_clk or negedge nrst) begin
			if (!nrst) begin
				line_oe_q[p] <= 1'b0;
			end else if (clk_en) begin
				line_oe_q[p] <= line_ctrl_q[OUT_B]; // R8
			end
		end

		// Priority: not an output, level mode, data access, release. An access that
		// lands with the status edge keeps the line low, so a request is never lost.
		always_ff @(posedge sys_clk or negedge nrst) begin
			if (!nrst) begin
				line_q[p] <= RST_LINE;
			end else if (clk_en) begin
				if (!line_ctrl_q[OUT_B]) begin
					line_q[p] <= RST_LINE;
				end else if (line_ctrl_q[LEVEL_B]) begin
					line_q[p] <= line_ctrl_q[MODE_B]; // R9 R11 R16
				end else if (data_acc[p]) begin
					line_q[p] <= 1'b0; // R12 R13 R16
				end else if (line_ctrl_q[MODE_B] || st_edge[p]) begin
					line_q[p] <= 1'b1; // R10 R12 R13
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Read data, registered one cycle after the read strobe
	// ------------------------------------------------------------
	// Unmapped indices read as zero. The value holds until the next read, so a
	// slow master may pick it up late.
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			bus_rdata <= RST_BYTE;
		end else if (clk_en && bus_rd) begin
			unique case (bus_addr)
				REG_PORTA_DATA: bus_rdata <= port_rd[0]; // R2
				REG_PORTB_DATA: bus_rdata <= port_rd[1]; // R2
				REG_PORTA_DIR:  bus_rdata <= dir_q[0];
				REG_PORTB_DIR:  bus_rdata <= dir_q[1];
				REG_AUX_CTRL:   bus_rdata <= aux_ctrl_q;
				REG_LINE_CTRL:  bus_rdata <= line_ctrl_q;
				REG_EVT_FLAGS: begin
					bus_rdata         <= RST_BYTE;
					bus_rdata[FLAG_A] <= flag_q[0]; // R4
					bus_rdata[FLAG_B] <= flag_q[1]; // R4
				end
				default:        bus_rdata <= RST_BYTE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Pin drivers
	// ------------------------------------------------------------
	// Outputs trail their registers by one cycle; every top-level output is a
	// flop so nothing combinational reaches the pads.
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			porta_pins_o  <= RST_BYTE;
			porta_pins_oe <= RST_BYTE;
			portb_pins_o  <= RST_BYTE;
			portb_pins_oe <= RST_BYTE;
		end else if (clk_en) begin
			porta_pins_o  <= out_q[0];
			porta_pins_oe <= dir_q[0]; // R1
			portb_pins_o  <= out_q[1];
			portb_pins_oe <= dir_q[1]; // R1
		end
	end

	// The control lines idle high while they are inputs, matching a pulled-up pad.
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			porta_control_line_o  <= RST_LINE;
			porta_control_line_oe <= 1'b0;
			portb_control_line_o  <= RST_LINE;
			portb_control_line_oe <= 1'b0;
		end else if (clk_en) begin
			porta_control_line_o  <= line_q[0];
			porta_control_line_oe <= line_oe_q[0];
			portb_control_line_o  <= line_q[1];
			portb_control_line_oe <= line_oe_q[1];
		end
	end

endmodule : pph_top

`default_nettype wire

// [test/pph_peer.sv]
// Peripheral model: drives port pins and answers a low control line with a status edge.
`timescale 1ns/1ps
`default_nettype none
module pph_peer (
	input  wire logic       sys_clk,
	input  wire logic       auto_en,
	input  wire logic       pol,
	input  wire logic [7:0] dly,
	input  wire logic       line_o,
	input  wire logic [7:0] pins_o,
	input  wire logic [7:0] pins_oe,
	input  wire logic [7:0] data,
	output var  logic [7:0] pins_i,
	output var  logic       status
);
	logic act = 1'b0;
	int   cnt = 0;
	// Driven bits win; released bits carry the peripheral's own byte.
	assign pins_i = (pins_oe & pins_o) | (~pins_oe & data);
	// Idle level is the inactive one, so a polarity change never looks like an event.
	assign status = act ~^ pol;
	task automatic fire;
		act = 1'b1;
		repeat (4) @(negedge sys_clk);
		act = 1'b0;
	endtask : fire
	always @(negedge sys_clk) begin
		cnt = (auto_en && !line_o) ? cnt + 1 : 0;
		if (auto_en && cnt == dly) begin
			fire();
		end
	end
endmodule : pph_peer
`default_nettype wire

// [test/pph_monitor.sv]
// Port-level assertions for the parallel port handshake block.
`timescale 1ns/1ps
`default_nettype none
module pph_monitor
	import pph_pkg::*;
(
	input wire logic              sys_clk,
	input wire logic              nrst,
	input wire logic              clk_en,
	input wire logic [ADDR_W-1:0] bus_addr,
	input wire logic              bus_rd,
	input wire logic              bus_wr,
	input wire logic [PORT_W-1:0] bus_wdata,
	input wire logic [PORT_W-1:0] bus_rdata,
	input wire logic [PORT_W-1:0] porta_pins_oe,
	input wire logic              porta_control_line_o,
	input wire logic              porta_control_line_oe,
	input wire logic              portb_control_line_o,
	input wire logic              portb_control_line_oe
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	logic [7:0] lc_q;
	logic [7:0] wd_q;
	wire        wr_c = clk_en && bus_wr && bus_addr == REG_LINE_CTRL;
	wire        wr_d = clk_en && bus_wr && bus_addr == REG_PORTA_DIR;
	wire        acc_a = clk_en && (bus_rd || bus_wr) && bus_addr == REG_PORTA_DATA;
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) lc_q <= RST_BYTE;
		else if (wr_c) lc_q <= bus_wdata;
	end
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) wd_q <= RST_BYTE;
		else if (bus_wr) wd_q <= bus_wdata;
	end
	a_line_oe_follow: assert property ($past(clk_en) && $past(clk_en, 2) |->
		porta_control_line_oe == $past(lc_q[3], 2) && portb_control_line_oe == $past(lc_q[7], 2))
		else $error("line oe");
	a_dir_oe: assert property (wr_d ##1 !bus_wr |=> porta_pins_oe == wd_q) else $error("dir oe");
	a_ctrl_readback: assert property (clk_en && bus_rd && !bus_wr && bus_addr == REG_LINE_CTRL
		|=> bus_rdata == lc_q) else $error("ctrl read");
	a_strobe_start: assert property (acc_a && lc_q[3:1] == 3'b101 && !wr_c
		|=> ##1 !porta_control_line_o) else $error("strobe start");
	a_strobe_width: assert property ($fell(porta_control_line_o) && lc_q[3:1] == 3'b101
		&& $stable(lc_q) |=> porta_control_line_o) else $error("strobe width");
	a_hs_low: assert property ($fell(porta_control_line_o) && lc_q[3:1] == 3'b100
		&& $stable(lc_q) |-> !porta_control_line_o [*2]) else $error("handshake");
	a_level_a: assert property (lc_q[3:2] == 2'b11 && $stable(lc_q) [*3] |->
		porta_control_line_o == lc_q[1] && porta_control_line_oe) else $error("level a");
	a_level_b: assert property (lc_q[7:6] == 2'b11 && $stable(lc_q) [*3] |->
		portb_control_line_o == lc_q[5] && portb_control_line_oe) else $error("level b");
	a_idle_high: assert property (!lc_q[3] && $stable(lc_q) [*3] |->
		porta_control_line_o && !porta_control_line_oe) else $error("idle line");
	c_strobe: cover property (acc_a && lc_q[3:1] == 3'b101);
	c_hs: cover property ($fell(porta_control_line_o) && lc_q[3:1] == 3'b100);
	c_level: cover property (lc_q[7:6] == 2'b11 && portb_control_line_o);
endmodule : pph_monitor
bind pph_top pph_monitor mon_u (.sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en),
	.bus_addr(bus_addr), .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_wdata(bus_wdata),
	.bus_rdata(bus_rdata), .porta_pins_oe(porta_pins_oe),
	.porta_control_line_o(porta_control_line_o), .porta_control_line_oe(porta_control_line_oe),
	.portb_control_line_o(portb_control_line_o), .portb_control_line_oe(portb_control_line_oe));
`default_nettype wire

// [test/testbench.sv]
// Self-checking bench for the parallel port handshake block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import pph_pkg::*;
	logic       sys_clk = 0, nrst = 0, clk_en = 1, bus_rd = 0, bus_wr = 0;
	logic [3:0] bus_addr = '0;
	logic [7:0] bus_wdata = '0, dly = 8'h03, r, v, dv, od;
	logic [7:0] bus_rdata;
	logic [7:0] lat_q [$];
	logic [7:0] pd [2] = '{8'h00, 8'h00};
	logic       au [2] = '{1'b0, 1'b0};
	logic       pl [2] = '{1'b0, 1'b0};
	wire  [7:0] po [2], poe [2], pi [2];
	wire  [1:0] ln, ln_oe, st;
	int         fails = 0, checked = 0, seed = 32'h821298DB, k, n;
	pph_top dut_u (.sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en), .bus_addr(bus_addr),
		.bus_rd(bus_rd), .bus_wr(bus_wr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
		.porta_pins_i(pi[0]), .porta_pins_o(po[0]), .porta_pins_oe(poe[0]),
		.portb_pins_i(pi[1]), .portb_pins_o(po[1]), .portb_pins_oe(poe[1]),
		.porta_status_input(st[0]), .portb_status_input(st[1]),
		.porta_control_line_o(ln[0]), .porta_control_line_oe(ln_oe[0]),
		.portb_control_line_o(ln[1]), .portb_control_line_oe(ln_oe[1]));
	pph_peer pa_u (.sys_clk(sys_clk), .auto_en(au[0]), .pol(pl[0]), .dly(dly), .line_o(ln[0]),
		.pins_o(po[0]), .pins_oe(poe[0]), .data(pd[0]), .pins_i(pi[0]), .status(st[0]));
	pph_peer pb_u (.sys_clk(sys_clk), .auto_en(au[1]), .pol(pl[1]), .dly(dly), .line_o(ln[1]),
		.pins_o(po[1]), .pins_oe(poe[1]), .data(pd[1]), .pins_i(pi[1]), .status(st[1]));
	initial forever #50 sys_clk = ~sys_clk;
	function automatic logic [3:0] dreg(input int p);
		return p ? REG_PORTB_DATA : REG_PORTA_DATA;
	endfunction : dreg
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		bus_addr = a;
		bus_wdata = d;
		bus_wr = 1'b1;
		@(negedge sys_clk);
		bus_wr = 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(negedge sys_clk);
		bus_addr = a;
		bus_rd = 1'b1;
		@(negedge sys_clk);
		bus_rd = 1'b0;
		d = bus_rdata;
	endtask : rd
	task automatic wrap_up;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : wrap_up
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (8) @(negedge sys_clk);
		nrst = 1'b1;
		rd(REG_LINE_CTRL, r);
		chk(r, 8'h00);
		for (int p = 0; p < 2; p++) begin
			dv = 8'($random(seed));
			od = 8'($random(seed));
			pd[p] = 8'($random(seed));
			wr(p ? REG_PORTB_DIR : REG_PORTA_DIR, dv);
			wr(dreg(p), od);
			repeat (6) @(negedge sys_clk);
			chk(po[p] & dv, od & dv);
			chk(poe[p], dv);
			rd(p ? REG_PORTB_DIR : REG_PORTA_DIR, r);
			chk(r, dv);
			rd(dreg(p), r);
			chk(r, (dv & od) | (~dv & pd[p]));
			wr(p ? REG_PORTB_DIR : REG_PORTA_DIR, 8'h00);
		end
		wr(REG_AUX_CTRL, 8'h03);
		rd(REG_AUX_CTRL, r);
		chk(r, 8'h03);
		for (int p = 0; p < 2; p++) begin
			for (int e = 0; e < 2; e++) begin
				pl[p] = e[0];
				wr(REG_LINE_CTRL, 8'(e << (4 * p)));
				v = 8'($random(seed));
				pd[p] = v;
				lat_q.push_back(v);
				repeat (8) @(negedge sys_clk);
				rd(dreg(p), r);
				if (p == 1) pb_u.fire();
				else pa_u.fire();
				pd[p] = ~v;
				repeat (8) @(negedge sys_clk);
				rd(REG_EVT_FLAGS, r);
				chk(r, 8'(1 << (p ? FLAG_B : FLAG_A)));
				rd(dreg(p), r);
				chk(r, lat_q.pop_front());
				rd(REG_EVT_FLAGS, r);
				chk(r, 8'h00);
			end
		end
		for (int p = 0; p < 2; p++) begin
			for (int m = 0; m < 4; m++) begin
				pl[p] = 1'b0;
				au[p] = 1'b1;
				dly = 8'(2 + $unsigned($random(seed)) % 4);
				wr(REG_LINE_CTRL, 8'((8'h08 + 2 * m) << (4 * p)));
				repeat (8) @(negedge sys_clk);
				rd(dreg(p), r);
				k = 0;
				n = 0;
				if (m < 2) begin
					while (ln[p] && k < 9) begin
						@(negedge sys_clk);
						k++;
					end
					while (!ln[p] && n < 40) begin
						@(negedge sys_clk);
						n++;
					end
					if (k == 9 || n == 40) begin
						fails++;
						$display("[FAIL] %0t control line wait timed out", $time);
						wrap_up();
					end
					chk(8'(m == 1 ? n == 1 : n > 2), 8'h01);
				end
				else chk({ln_oe[p], ln[p]}, {1'b1, m == 3});
				au[p] = 1'b0;
			end
		end
		clk_en = 1'b0;
		wr(REG_LINE_CTRL, 8'h00);
		clk_en = 1'b1;
		rd(REG_LINE_CTRL, r);
		chk(r, 8'hE0);
		chk({ln_oe[1], ln[1]}, 8'h03);
		wr(REG_LINE_CTRL, 8'h00);
		repeat (4) @(negedge sys_clk);
		chk({ln_oe, ln}, 8'h03);
		wrap_up();
	end
endmodule : testbench
`default_nettype wire
